// ### logic/sfs_defs.vh
// constants for the serial flash front end: opcodes, status layout, timing
// assumes a 125 MHz system clock and the includer's default net handling
//
// Overview of operation
// - command, address and input bits are taken on serial clock rising edges
// - output bits change on serial clock falling edges for the next rising edge
// - dual mode uses both lanes for input or output, same edges
// - clock may idle low or high; edges used are the same
// - after power-on the shared pin is an active-low reset
// - pause enable command turns the pin into hold until power cycle
// - with the pin as reset and high, the device runs normally
// - output floats in reset, within 105 ns of assertion
// - completed reset restores status: lock, busy, write latch 0, protect bits 1
// - reset during program or erase aborts it; target data undefined
// - hold while selected pauses transfer and keeps the command in progress
// - array erases in 4 KB sectors and 32 KB and 64 KB blocks
// - write protect input enables the lock effect of the protection lock bit
// - 256-bit one-time id: 64 factory bits and 192 user bits
// - hold starts and ends only while serial clock is low
// - in hold the output floats and clock and input are ignored
// - select rising in hold returns to standby; resume needs hold off, select low
// - status bits: busy 0, latch 1, protect 2 to 5, id lock 6, lock 7
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// opcodes
`define SFS_OP_STATUS_WRITE 8'h01
`define SFS_OP_PAGE_PROG    8'h02
`define SFS_OP_READ         8'h03
`define SFS_OP_WRITE_DIS    8'h04
`define SFS_OP_STATUS_READ  8'h05
`define SFS_OP_WRITE_EN     8'h06
`define SFS_OP_FAST_READ    8'h0b
`define SFS_OP_SECT_ERASE   8'h20
`define SFS_OP_DUAL_OUT_RD  8'h3b
`define SFS_OP_BLK32_ERASE  8'h52
`define SFS_OP_CHIP_ERASE_A 8'h60
`define SFS_OP_DUAL_PROG    8'ha2
`define SFS_OP_PAUSE_EN     8'haa
`define SFS_OP_DUAL_IO_RD   8'hbb
`define SFS_OP_CHIP_ERASE_B 8'hc7
`define SFS_OP_BLK64_ERASE  8'hd8

// status register fields
`define SFS_ST_BUSY  0
`define SFS_ST_WEL   1
`define SFS_ST_BP_LO 2
`define SFS_ST_BP_HI 5
`define SFS_ST_SEC   6
`define SFS_ST_BPL   7
`define SFS_BP_RESET 4'hf

// array geometry
`define SFS_PAGE_BYTES   9'h100
`define SFS_SECT_MASK    24'hfff000
`define SFS_BLK32_MASK   24'hff8000
`define SFS_BLK64_MASK   24'hff0000
`define SFS_SID_BITS     256
`define SFS_SID_FACT     64
`define SFS_SID_USER     192

// timing, figures in ns, us or ms and derived cycle counts
`define SFS_CLK_NS        8
`define SFS_T_RST_NS      100
`define SFS_T_FLOAT_NS    105
`define SFS_T_REC_RD_NS   100
`define SFS_T_REC_PG_US   10
`define SFS_T_REC_ER_MS   1
`define SFS_RST_CYC       ((`SFS_T_RST_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)
`define SFS_FLOAT_CYC     (`SFS_T_FLOAT_NS / `SFS_CLK_NS)
`define SFS_REC_RD_CYC    (`SFS_T_REC_RD_NS / `SFS_CLK_NS)
`define SFS_REC_PG_CYC    ((`SFS_T_REC_PG_US * 1000) / `SFS_CLK_NS)
`define SFS_REC_ER_CYC    ((`SFS_T_REC_ER_MS * 1000000) / `SFS_CLK_NS)

`endif

// ### logic/sfs_buf2.v
// two-entry valid/ready buffer for the program data stream
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module sfs_buf2 #(
  parameter W = 8
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // filling side
  input  wire         i_in_valid,
  output wire         o_in_ready,
  input  wire [W-1:0] i_in_data,
  // draining side
  output wire         o_out_valid,
  input  wire         i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] head_q;
  reg [W-1:0] tail_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  // handshakes
  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = head_q;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage, head is always the oldest word
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q  <= 2'h0;
      head_q <= {W{1'b0}};
      tail_q <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) head_q <= i_in_data;
          else tail_q <= i_in_data;
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          head_q <= tail_q;
          cnt_q  <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) head_q <= i_in_data;
          else begin
            head_q <= tail_q;
            tail_q <= i_in_data;
          end
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule // sfs_buf2
`default_nettype wire

// ### logic/sfs_front_end.v
// serial flash front end: spi pins, shared reset/hold pin, status register
// assumes the array engine on the user side answers reads within 4 cycles
`timescale 1ns/10ps
`default_nettype none
`include "sfs_defs.vh"
module sfs_front_end #(
  parameter REC_ERASE_CYC = `SFS_REC_ER_CYC,
  parameter PAGE_BYTES    = 256
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // serial pins
  input  wire        i_sck,
  input  wire        i_cs_n,
  input  wire        i_rst_hold_n,
  input  wire        i_wp_n,
  input  wire [1:0]  i_dual_lane_io,
  output reg  [1:0]  o_dual_lane_io,
  output wire [1:0]  o_dual_lane_io_oe,
  // commands to the array engine
  output reg         o_cmd_valid,
  output reg  [7:0]  o_cmd_op,
  output reg  [23:0] o_cmd_addr,
  output reg  [8:0]  o_cmd_len,
  output reg         o_abort,
  input  wire        i_array_busy,
  input  wire        i_sec_locked,
  // array read port
  output reg         o_rd_req,
  output reg  [23:0] o_rd_addr,
  input  wire        i_rd_valid,
  input  wire [7:0]  i_rd_data,
  // program data stream
  output wire        o_wr_valid,
  input  wire        i_wr_ready,
  output wire [7:0]  o_wr_data,
  // status
  output wire [7:0]  o_status,
  output reg         o_pause_mode,
  output reg         o_hold,
  output wire        o_in_reset,
  output wire        o_recovering,
  output reg         o_overrun
);
  // engine states
  localparam ST_IDLE  = 4'h0;
  localparam ST_OP    = 4'h1;
  localparam ST_ADDR  = 4'h2;
  localparam ST_DUMMY = 4'h3;
  localparam ST_RDATA = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_SRW   = 4'h6;
  localparam ST_SRR   = 4'h7;
  localparam ST_END   = 4'h8;
  localparam ST_SKIP  = 4'h9;
  // kinds of work that reset may interrupt
  localparam K_NONE = 2'h0;
  localparam K_PROG = 2'h1;
  localparam K_ERAS = 2'h2;
  localparam [16:0] RST_CYC = `SFS_RST_CYC;
  localparam [16:0] REC_PG_CYC = `SFS_REC_PG_CYC;
  localparam [16:0] REC_RD_CYC = `SFS_REC_RD_CYC;

  //--------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------
  reg [5:0] s1_q;
  reg [5:0] s2_q;
  reg       sck_d1_q;
  reg       cs_d1_q;
  wire      sck_s = s2_q[0];
  wire      cs_s  = s2_q[1];
  wire      rh_s  = s2_q[2];
  wire      wp_s  = s2_q[3];
  wire [1:0] din  = s2_q[5:4];

  // two flops for every pin
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_q     <= 6'h0f;
      s2_q     <= 6'h0f;
      sck_d1_q <= 1'b1;  // same level as s2_q, no false edge
      cs_d1_q  <= 1'b1;
    end else begin
      s1_q     <= {i_dual_lane_io, i_wp_n, i_rst_hold_n, i_cs_n, i_sck};
      s2_q     <= s1_q;
      sck_d1_q <= sck_s;
      cs_d1_q  <= cs_s;
    end
  end

  //--------------------------------------------------------------
  // reset, hold and recovery
  //--------------------------------------------------------------
  reg [16:0] rst_cnt_q;
  reg [16:0] rec_cnt_q;
  reg [1:0]  kind_q;
  reg        rst_hit_q;
  wire       rst_low   = ~o_pause_mode & ~rh_s;
  wire       rst_apply = rst_low & (rst_cnt_q == RST_CYC - 17'h1);
  assign o_in_reset   = rst_low;
  assign o_recovering = (rec_cnt_q != 17'h0);

  // reset width count, recovery wait and hold tracking
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_cnt_q <= 17'h0;
      rec_cnt_q <= 17'h0;
      rst_hit_q <= 1'b0;
      o_abort   <= 1'b0;
      o_hold    <= 1'b0;
    end else begin
      o_abort <= 1'b0;
      if (rst_low) begin
        if (rst_cnt_q != RST_CYC) rst_cnt_q <= rst_cnt_q + 17'h1;
        if (rst_apply) begin
          rst_hit_q <= 1'b1;
          o_abort   <= i_array_busy;
          case (kind_q)
            K_PROG:  rec_cnt_q <= REC_PG_CYC;
            K_ERAS:  rec_cnt_q <= REC_ERASE_CYC[16:0];
            default: rec_cnt_q <= REC_RD_CYC;
          endcase
        end
      end else begin
        rst_cnt_q <= 17'h0;
        rst_hit_q <= 1'b0;
        if (rec_cnt_q != 17'h0 && !rst_hit_q) rec_cnt_q <= rec_cnt_q - 17'h1;
        else if (rst_hit_q) rec_cnt_q <= rec_cnt_q;
      end
      // hold changes only while the serial clock is low
      if (!sck_s) o_hold <= o_pause_mode & ~rh_s & ~cs_s;
    end
  end

  //--------------------------------------------------------------
  // serial edges
  //--------------------------------------------------------------
  wire run     = ~rst_low & ~o_hold & ~o_recovering;
  wire rise    = run & sck_s & ~sck_d1_q & ~cs_s;
  wire fall    = run & ~sck_s & sck_d1_q & ~cs_s;
  wire cs_fall = ~cs_s & cs_d1_q;
  wire cs_rise = cs_s & ~cs_d1_q;

  //--------------------------------------------------------------
  // status register
  //--------------------------------------------------------------
  reg       wel_q;
  reg [3:0] bp_q;
  reg       bpl_q;
  assign o_status = {bpl_q, i_sec_locked, bp_q, wel_q, i_array_busy};

  //--------------------------------------------------------------
  // command engine
  //--------------------------------------------------------------
  reg [3:0]  state_q;
  reg [7:0]  op_q;
  reg [7:0]  sh_in_q;
  reg [3:0]  bits_q;
  reg [1:0]  abytes_q;
  reg        dummy_q;
  reg        dual_in_q;
  reg        dual_out_q;
  reg [23:0] addr_q;
  reg [7:0]  sh_out_q;
  reg [3:0]  obits_q;
  reg [7:0]  nxt_q;
  reg [8:0]  page_q;
  reg [7:0]  srw_q;
  reg [1:0]  oe_q;
  reg        wpend_q;
  reg [7:0]  wbyte_q;
  wire       buf_ready;
  wire [3:0] bits_nx = bits_q + (dual_in_q ? 4'h2 : 4'h1);
  wire [7:0] sh_nx   = dual_in_q ? {sh_in_q[5:0], din[1], din[0]} : {sh_in_q[6:0], din[0]};
  wire       byte_in = rise & (bits_nx == 4'h8);
  wire       is_prog = (op_q == `SFS_OP_PAGE_PROG) | (op_q == `SFS_OP_DUAL_PROG);
  wire       is_read = (op_q == `SFS_OP_READ) | (op_q == `SFS_OP_FAST_READ) |
                       (op_q == `SFS_OP_DUAL_OUT_RD) | (op_q == `SFS_OP_DUAL_IO_RD);
  wire       sr_ok   = wel_q & ~(~wp_s & bpl_q);
  wire [7:0] sh_top  = dual_out_q ? {sh_out_q[5:0], 2'b00} : {sh_out_q[6:0], 1'b0};

  // next opcode state, decided when the first byte completes
  reg [3:0] op_state;
  always @* begin
    op_state = ST_SKIP;
    case (sh_nx)
      `SFS_OP_STATUS_READ: op_state = ST_SRR;
      `SFS_OP_WRITE_EN, `SFS_OP_WRITE_DIS, `SFS_OP_PAUSE_EN:
        op_state = i_array_busy ? ST_SKIP : ST_END;
      `SFS_OP_STATUS_WRITE: op_state = i_array_busy ? ST_SKIP : ST_SRW;
      `SFS_OP_READ, `SFS_OP_FAST_READ, `SFS_OP_DUAL_OUT_RD, `SFS_OP_DUAL_IO_RD:
        op_state = i_array_busy ? ST_SKIP : ST_ADDR;
      `SFS_OP_PAGE_PROG, `SFS_OP_DUAL_PROG, `SFS_OP_SECT_ERASE,
      `SFS_OP_BLK32_ERASE, `SFS_OP_BLK64_ERASE:
        op_state = (i_array_busy | ~wel_q) ? ST_SKIP : ST_ADDR;
      `SFS_OP_CHIP_ERASE_A, `SFS_OP_CHIP_ERASE_B:
        op_state = (i_array_busy | ~wel_q | (bp_q != 4'h0)) ? ST_SKIP : ST_END;
      default: op_state = ST_SKIP;
    endcase
  end

  // sequencer, input shifting on rising edges, output on falling edges
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;   op_q <= 8'h00;   sh_in_q <= 8'h00;
      bits_q <= 4'h0;       abytes_q <= 2'h0; dummy_q <= 1'b0;
      dual_in_q <= 1'b0;    dual_out_q <= 1'b0; addr_q <= 24'h000000;
      sh_out_q <= 8'h00;    obits_q <= 4'h0; nxt_q <= 8'h00;
      page_q <= 9'h000;     srw_q <= 8'h00;  oe_q <= 2'b00;
      o_dual_lane_io <= 2'b00;
      wpend_q <= 1'b0;      wbyte_q <= 8'h00; o_overrun <= 1'b0;
      o_rd_req <= 1'b0;     o_rd_addr <= 24'h000000;
      o_cmd_valid <= 1'b0;  o_cmd_op <= 8'h00; o_cmd_addr <= 24'h000000;
      o_cmd_len <= 9'h000;  kind_q <= K_NONE; o_pause_mode <= 1'b0;
      wel_q <= 1'b0;        bp_q <= `SFS_BP_RESET; bpl_q <= 1'b0;
    end else begin
      o_rd_req    <= 1'b0;
      o_cmd_valid <= 1'b0;
      if (!i_array_busy && !o_cmd_valid) kind_q <= K_NONE;
      if (wpend_q && buf_ready) wpend_q <= 1'b0;
      if (i_rd_valid) nxt_q <= i_rd_data;
      if (rst_apply) begin
        // completed reset: power-up status, engine back to standby
        wel_q   <= 1'b0;
        bp_q    <= `SFS_BP_RESET;
        bpl_q   <= 1'b0;
        state_q <= ST_IDLE;
        oe_q    <= 2'b00;
      end else if (rst_low || cs_s) begin
        if (cs_rise && !rst_low) begin
          // command completion happens only on a whole command
          case (state_q)
            ST_END: begin
              case (op_q)
                `SFS_OP_WRITE_EN:  wel_q <= 1'b1;
                `SFS_OP_WRITE_DIS: wel_q <= 1'b0;
                `SFS_OP_PAUSE_EN:  o_pause_mode <= 1'b1;
                `SFS_OP_STATUS_WRITE: begin
                  wel_q <= 1'b0;
                  if (sr_ok) begin
                    bp_q  <= srw_q[`SFS_ST_BP_HI:`SFS_ST_BP_LO];
                    bpl_q <= srw_q[`SFS_ST_BPL];
                  end
                end
                default: begin
                  // erases, aligned to their unit size
                  wel_q       <= 1'b0;
                  kind_q      <= K_ERAS;
                  o_cmd_valid <= 1'b1;
                  o_cmd_op    <= op_q;
                  o_cmd_len   <= 9'h000;
                  case (op_q)
                    `SFS_OP_SECT_ERASE:  o_cmd_addr <= addr_q & `SFS_SECT_MASK;
                    `SFS_OP_BLK32_ERASE: o_cmd_addr <= addr_q & `SFS_BLK32_MASK;
                    `SFS_OP_BLK64_ERASE: o_cmd_addr <= addr_q & `SFS_BLK64_MASK;
                    default:             o_cmd_addr <= 24'h000000;
                  endcase
                end
              endcase
            end
            ST_WDATA: begin
              if (page_q != 9'h000) begin
                wel_q       <= 1'b0;
                kind_q      <= K_PROG;
                o_cmd_valid <= 1'b1;
                o_cmd_op    <= op_q;
                o_cmd_addr  <= addr_q;
                o_cmd_len   <= page_q;
              end
            end
            default: wel_q <= wel_q;
          endcase
        end
        state_q <= ST_IDLE;
        oe_q    <= 2'b00;
      end else begin
        if (cs_fall && state_q == ST_IDLE) begin
          state_q   <= ST_OP;
          bits_q    <= 4'h0;
          dual_in_q <= 1'b0;
          dual_out_q <= 1'b0;
          page_q    <= 9'h000;
          obits_q   <= 4'h0;
          o_overrun <= 1'b0;
        end
        if (rise) begin
          sh_in_q <= sh_nx;
          bits_q  <= byte_in ? 4'h0 : bits_nx;
        end
        if (byte_in) begin
          case (state_q)
            ST_OP: begin
              op_q     <= sh_nx;
              state_q  <= op_state;
              abytes_q <= 2'h0;
              dummy_q  <= (sh_nx != `SFS_OP_READ);
              dual_in_q <= (sh_nx == `SFS_OP_DUAL_IO_RD);
              dual_out_q <= (sh_nx == `SFS_OP_DUAL_OUT_RD) | (sh_nx == `SFS_OP_DUAL_IO_RD);
            end
            ST_ADDR: begin
              addr_q   <= {addr_q[15:0], sh_nx};
              abytes_q <= abytes_q + 2'h1;
              if (abytes_q == 2'h2) begin
                if (is_read) begin
                  o_rd_req  <= 1'b1;
                  o_rd_addr <= {addr_q[15:0], sh_nx};
                  state_q   <= dummy_q ? ST_DUMMY : ST_RDATA;
                end else if (is_prog) begin
                  state_q   <= ST_WDATA;
                  dual_in_q <= (op_q == `SFS_OP_DUAL_PROG);
                end else state_q <= ST_END;
              end
            end
            ST_DUMMY: state_q <= ST_RDATA;
            ST_SRW: begin
              srw_q   <= sh_nx;
              state_q <= ST_END;
            end
            ST_WDATA: begin
              // bytes past one page are dropped
              if (page_q != PAGE_BYTES[8:0]) begin
                page_q  <= page_q + 9'h001;
                wbyte_q <= sh_nx;
                wpend_q <= 1'b1;
                if (wpend_q && !buf_ready) o_overrun <= 1'b1;
              end
            end
            default: state_q <= state_q;
          endcase
        end
        if (fall && (state_q == ST_RDATA || state_q == ST_SRR)) begin
          oe_q <= dual_out_q ? 2'b11 : 2'b10;
          if (obits_q == 4'h0) begin
            sh_out_q <= (state_q == ST_SRR) ? {o_status[5:0], 2'b00} : {nxt_q[5:0], 2'b00};
            if (!dual_out_q)
              sh_out_q <= (state_q == ST_SRR) ? {o_status[6:0], 1'b0} : {nxt_q[6:0], 1'b0};
            o_dual_lane_io <= (state_q == ST_SRR) ? o_status[7:6] : nxt_q[7:6];
            if (!dual_out_q)
              o_dual_lane_io <= {((state_q == ST_SRR) ? o_status[7] : nxt_q[7]), 1'b0};
            obits_q <= dual_out_q ? 4'h6 : 4'h7;
            if (state_q == ST_RDATA) begin
              o_rd_req  <= 1'b1;                               // prefetch next byte
              o_rd_addr <= o_rd_addr + 24'h000001;
            end
          end else begin
            sh_out_q       <= sh_top;
            o_dual_lane_io <= dual_out_q ? sh_out_q[7:6] : {sh_out_q[7], 1'b0};
            obits_q        <= obits_q - (dual_out_q ? 4'h2 : 4'h1);
          end
        end
      end
    end
  end

  // float while in reset, in hold or deselected
  assign o_dual_lane_io_oe = oe_q & {2{run & ~cs_s}};

  //--------------------------------------------------------------
  // program data buffer
  //--------------------------------------------------------------
  sfs_buf2 #(
    .W (8)
  ) u_buf (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (wpend_q),
    .o_in_ready  (buf_ready),
    .i_in_data   (wbyte_q),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (o_wr_data)
  );
endmodule // sfs_front_end
`default_nettype wire

// ### verification/sfs_front_end_monitor.sv
// checker on the ports of the serial flash front end
// assumes one i_clk domain with a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module sfs_front_end_monitor (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  // pins
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_rst_hold_n,
  input wire logic [1:0] o_dual_lane_io,
  input wire logic [1:0] o_dual_lane_io_oe,
  // status and commands
  input wire logic [7:0] o_status,
  input wire logic       o_cmd_valid,
  input wire logic       o_abort,
  input wire logic       o_pause_mode,
  input wire logic       o_hold,
  input wire logic       o_in_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_float_in_reset: assert property (o_in_reset |-> o_dual_lane_io_oe == 2'b00)
    else $error("lanes driven in reset");
  a_float_in_time: assert property ($fell(i_rst_hold_n) && !o_pause_mode |-> ##[1:13] !o_dual_lane_io_oe)
    else $error("lanes not floated in time");
  a_float_in_hold: assert property (o_hold |-> o_dual_lane_io_oe == 2'b00)
    else $error("lanes driven in hold");
  a_hold_needs_pause: assert property (o_hold |-> o_pause_mode)
    else $error("hold while pin is reset");
  a_pause_sticky: assert property (o_pause_mode |=> o_pause_mode)
    else $error("pause mode reverted");
  a_pause_no_reset: assert property (o_pause_mode |-> !o_in_reset)
    else $error("reset taken in pause mode");
  a_drive_after_fall: assert property (o_dual_lane_io_oe[1] && $changed(o_dual_lane_io[1]) |-> !i_sck && !$past(i_sck))
    else $error("output changed outside clock low");
  a_commit_after_rise: assert property (o_cmd_valid |-> i_cs_n && $past(i_cs_n, 2) ##1 !o_cmd_valid)
    else $error("commit before select rose");
  a_abort_in_reset: assert property (o_abort |-> o_in_reset && $past(o_in_reset, 8))
    else $error("abort outside completed reset");
  a_status_restored: assert property (o_in_reset[*8] ##1 o_in_reset[*8] |-> {o_status[7], o_status[5:1]} == 6'h1e)
    else $error("status not restored by reset");
endmodule  // sfs_front_end_monitor
bind sfs_front_end sfs_front_end_monitor u_mon (.*);
`default_nettype wire

// ### verification/sfs_host_model.sv
// spi host model: link clock, select and lanes, mode 0 or mode 3
// assumes a 125 MHz pacing clock; link clock period is 160 ns
`timescale 1ns/10ps
`default_nettype none
module sfs_host_model (
  // pacing clock
  input  wire logic       i_clk,
  // spi pins
  output var logic        o_sck,
  output var logic        o_cs_n,
  output var logic [1:0]  o_lane,
  output var logic [1:0]  o_lane_oe,
  input  wire logic [1:0] i_lane
);
  logic mode3 = 1'b0;  // idle level of the link clock
  // idle bus
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_lane = 2'b00;
    o_lane_oe = 2'b00;
  end
  // half link period, far below every read clock limit
  task automatic half();
    repeat (10) @(posedge i_clk);
    #1;
  endtask
  // select falls first, then the clock is set low
  task automatic start();
    half();
    o_cs_n = 1'b0;
    half();
    o_sck = 1'b0;
  endtask
  // one byte msb first; lane1 carries the higher bit in dual
  task automatic xfer(input logic [7:0] d, input bit dual, input bit drv, output logic [7:0] q);
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      o_lane_oe = drv ? {dual, 1'b1} : 2'b00;
      o_lane = dual ? d[7-2*i -: 2] : {1'b0, d[7-i]};
      half();
      o_sck = 1'b1;
      q = dual ? {q[5:0], i_lane} : {q[6:0], i_lane[1]};
      half();
      o_sck = 1'b0;
    end
  endtask
  // select rises, clock back to idle level
  task automatic stop();
    half();
    o_cs_n = 1'b1;
    o_lane_oe = 2'b00;
    half();
    o_sck = mode3;
  endtask
endmodule  // sfs_host_model
`default_nettype wire

// ### verification/sfs_front_end_bench.sv
// self-checking bench for the serial flash front end
// assumes the host model on the pins and a small array engine here
`timescale 1ns/10ps
`default_nettype none
module sfs_front_end_bench;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_rst_hold_n = 1'b1, i_array_busy = 1'b0;
  logic        i_rd_valid = 1'b0, i_wr_ready = 1'b0, abort_seen = 1'b0;
  logic        i_wp_n = 1'b1, i_sec_locked = 1'b0;
  logic        i_sck, i_cs_n, o_cmd_valid, o_abort, o_rd_req, o_wr_valid, o_pause_mode;
  logic        o_hold, o_in_reset, o_recovering, o_overrun;
  logic [1:0]  i_dual_lane_io, o_dual_lane_io, o_dual_lane_io_oe, h_lane, h_oe;
  logic [7:0]  i_rd_data = 8'h00, o_cmd_op, o_wr_data, o_status, q;
  logic [8:0]  o_cmd_len;
  logic [23:0] o_cmd_addr, o_rd_addr;
  int          n_mismatch = 0, n_compared = 0;
  sfs_front_end #(.REC_ERASE_CYC(40), .PAGE_BYTES(256)) dut (.*);
  sfs_host_model host (.i_clk(i_clk), .o_sck(i_sck), .o_cs_n(i_cs_n),
                       .o_lane(h_lane), .o_lane_oe(h_oe), .i_lane(i_dual_lane_io));
  // lane level: device, else host, else inverse of the last host value
  assign i_dual_lane_io = (o_dual_lane_io_oe & o_dual_lane_io) | (~o_dual_lane_io_oe & (h_oe ~^ h_lane));
  initial forever #4 i_clk = ~i_clk;
  // array engine: data one cycle after each request
  always @(posedge i_clk) begin
    i_rd_valid <= #1 o_rd_req;
    i_rd_data <= #1 o_rd_addr[7:0] ^ 8'h5a;
    if (o_abort) abort_seen <= #1 1'b1;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for a commit pulse or for recovery to end
  task automatic wait_for(input bit commit, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge i_clk);
      #1;
      if ((commit ? o_cmd_valid : !o_recovering) === 1'b1) break;
    end
    if (i == lim) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic open_cmd(input logic [7:0] op, input logic [23:0] a, input int na);
    host.start();
    host.xfer(op, 0, 1, q);
    for (int k = 0; k < na; k++) host.xfer(a[23-8*k -: 8], 0, 1, q);
  endtask
  task automatic status_is(input logic [7:0] exp);
    open_cmd(8'h05, 24'h0, 0);
    host.xfer(8'h00, 0, 0, q);
    host.stop();
    check("status", q, exp);
  endtask
  task automatic sc_read();
    open_cmd(8'h03, 24'h123456, 3);
    host.xfer(8'h00, 0, 0, q);
    check("read 0", q, 8'h56 ^ 8'h5a);
    host.xfer(8'h00, 0, 0, q);
    check("read 1", q, 8'h57 ^ 8'h5a);
    host.stop();
    open_cmd(8'h3b, 24'h000010, 3);
    host.xfer(8'h00, 0, 1, q);
    host.xfer(8'h00, 1, 0, q);
    host.stop();
    check("dual read", q, 8'h10 ^ 8'h5a);
    host.start();
    host.xfer(8'hbb, 0, 1, q);
    for (int k = 0; k < 4; k++) host.xfer((k == 3) ? 8'h00 : 8'h21, 1, 1, q);
    host.xfer(8'h00, 1, 0, q);
    host.stop();
    check("dual io read", q, 8'h21 ^ 8'h5a);
    host.mode3 = 1'b1;
    host.stop();
    status_is(8'h3c);
    host.mode3 = 1'b0;
    host.stop();
  endtask
  task automatic sc_erase();
    open_cmd(8'h06, 24'h0, 0);
    host.stop();
    status_is(8'h3e);
    open_cmd(8'h20, 24'h012345, 2);
    host.stop();
    status_is(8'h3e);
    open_cmd(8'h20, 24'h012345, 3);
    fork
      host.stop();
      begin
        wait_for(1, 50);
        i_array_busy = 1'b1;
      end
    join
    check("erase op", o_cmd_op, 8'h20);
    check("erase addr", o_cmd_addr, 24'h012000);
    open_cmd(8'h05, 24'h0, 0);
    host.xfer(8'h00, 0, 0, q);
    check("busy status", q, 8'h3d);
    i_rst_hold_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 check("float", o_dual_lane_io_oe, 2'b00);
    repeat (17) @(posedge i_clk);
    #1 i_rst_hold_n = 1'b1;
    i_array_busy = 1'b0;
    host.stop();
    check("abort", abort_seen, 1'b1);
    wait_for(0, 200);
    status_is(8'h3c);
  endtask
  task automatic sc_program();
    open_cmd(8'h06, 24'h0, 0);
    host.stop();
    open_cmd(8'ha2, 24'h000100, 3);
    host.xfer(8'ha5, 1, 1, q);
    host.xfer(8'h3c, 1, 1, q);
    fork
      host.stop();
      wait_for(1, 50);
    join
    check("prog len", o_cmd_len, 9'h002);
    check("stalled head", {o_overrun, o_wr_valid, o_wr_data}, 10'h1a5);
    @(posedge i_clk);
    #1 i_wr_ready = 1'b1;
    @(posedge i_clk);
    #1 check("second", {o_wr_valid, o_wr_data}, 9'h13c);
    @(posedge i_clk);
    #1 i_wr_ready = 1'b0;
    check("drained", o_wr_valid, 1'b0);
  endtask
  // status write allowed with protect high, refused once locked with protect low
  task automatic sc_lock();
    for (int k = 0; k < 2; k++) begin
      i_wp_n = (k == 0);
      open_cmd(8'h06, 24'h0, 0);
      host.stop();
      open_cmd(8'h01, (k == 0) ? 24'h800000 : 24'h3c0000, 1);
      host.stop();
      status_is(8'h80);
    end
    i_wp_n = 1'b1;
  endtask
  task automatic sc_pause();
    open_cmd(8'haa, 24'h0, 0);
    host.stop();
    check("pause mode", o_pause_mode, 1'b1);
    open_cmd(8'h03, 24'h000020, 3);
    i_rst_hold_n = 1'b0;
    repeat (20) @(posedge i_clk);
    #1 check("hold", {o_hold, o_in_reset, o_dual_lane_io_oe}, 4'h8);
    i_rst_hold_n = 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    host.xfer(8'h00, 0, 0, q);
    host.stop();
    check("held read", q, 8'h20 ^ 8'h5a);
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    check("power cycle", {o_pause_mode, o_status}, 9'h03c);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    sc_read();
    sc_erase();
    sc_program();
    sc_lock();
    sc_pause();
    print_verdict();
  end
endmodule  // sfs_front_end_bench
`default_nettype wire
